//--- inc/aau_pkg.sv
/*
 * Shared types and constants of the accumulator arithmetic unit:
 * instruction and addressing encodings, request and memory carriers,
 * reset values, cycle and length figures per instruction form.
 * Assumes the instruction decoder speaks these same types.
 */
package aau_pkg;

    // Operations the unit executes
    typedef enum logic [3:0] {
        OP_ADD,
        OP_ADD_WITH_CARRY,
        OP_SUBTRACT_WITH_BORROW,
        OP_INCREMENT,
        OP_DECREMENT,
        OP_INC_DATA_POINTER,
        OP_MULTIPLY,
        OP_DIVIDE,
        OP_LOAD_ACC,
        OP_LOAD_AUX,
        OP_LOAD_CARRY
    } aau_op_e;

    // Where the operand comes from
    typedef enum logic [2:0] {
        MD_ACC,
        MD_WORKING_REG,
        MD_DIRECT,
        MD_INDIRECT,
        MD_IMMEDIATE
    } aau_mode_e;

    // One instruction handed over by the decoder
    typedef struct packed {
        aau_op_e op;
        aau_mode_e mode;
        logic [7:0] operand; // Working register value or immediate byte
        logic [7:0] addr; // Direct address, or pointer held in indirect register
    } aau_req_s;

    // Internal data memory strobes
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } aau_mem_s;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] AUX_RST = 8'h00;
    localparam logic [15:0] DP_RST = 16'h0000;
    localparam logic CARRY_RST = 1'b0;

    // Cycle counts per instruction form
    localparam logic [2:0] CYC_REG_ARITH = 3'h1;
    localparam logic [2:0] CYC_MEM_ARITH = 3'h2;
    localparam logic [2:0] CYC_ACC_STEP = 3'h1;
    localparam logic [2:0] CYC_REG_STEP = 3'h2;
    localparam logic [2:0] CYC_MEM_STEP = 3'h3;
    localparam logic [2:0] CYC_DP_STEP = 3'h1;
    localparam logic [2:0] CYC_MULTIPLY = 3'h2;
    localparam logic [2:0] CYC_DIVIDE = 3'h6;
    localparam logic [2:0] CYC_LOAD = 3'h1;
    // Cycle in which a memory step writes back (count still to run)
    localparam logic [2:0] CNT_STEP_WRITE = 3'h2;
    localparam logic [2:0] CNT_LAST = 3'h1;

    // Instruction lengths in bytes
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;

    // True when the operand is fetched from data memory
    function automatic logic aau_uses_mem(input aau_mode_e mode);
        aau_uses_mem = (mode == MD_DIRECT) || (mode == MD_INDIRECT);
    endfunction

    // Execution time of an instruction form
    function automatic logic [2:0] aau_cycles(input aau_op_e op, input aau_mode_e mode);
        logic mem;
        mem = aau_uses_mem(mode);
        case (op)
            OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW: begin
                aau_cycles = (mem || mode == MD_IMMEDIATE) ? CYC_MEM_ARITH : CYC_REG_ARITH;
            end
            OP_INCREMENT, OP_DECREMENT: begin
                aau_cycles = mem ? CYC_MEM_STEP :
                             (mode == MD_WORKING_REG) ? CYC_REG_STEP : CYC_ACC_STEP;
            end
            OP_INC_DATA_POINTER: aau_cycles = CYC_DP_STEP;
            OP_MULTIPLY: aau_cycles = CYC_MULTIPLY;
            OP_DIVIDE: aau_cycles = CYC_DIVIDE;
            default: aau_cycles = CYC_LOAD;
        endcase
    endfunction

    // Encoded length of an instruction form
    function automatic logic [1:0] aau_bytes(input aau_op_e op, input aau_mode_e mode);
        case (op)
            OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INCREMENT,
            OP_DECREMENT, OP_LOAD_ACC, OP_LOAD_AUX: begin
                aau_bytes = (mode == MD_DIRECT || mode == MD_IMMEDIATE) ? LEN_TWO : LEN_ONE;
            end
            default: aau_bytes = LEN_ONE;
        endcase
    endfunction

endpackage

//--- logic/aau_divider.sv
/*
 * Unsigned 8-by-8 restoring divider, purely combinational.
 * Assumes the caller holds its inputs steady and samples the answer
 * only after the full divide time has elapsed.
 */
`timescale 1ns/1ns
`default_nettype none

module aau_divider (
    input wire logic [7:0] dividend,
    input wire logic [7:0] divisor,
    output logic [7:0] quotient,
    output logic [7:0] remainder,
    output logic div_zero
);

    // One restoring step per quotient bit, most significant first
    always_comb begin
        logic [8:0] part;
        part = 9'h000;
        quotient = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            part = {part[7:0], dividend[i]};
            if (part >= {1'b0, divisor}) begin
                part = part - {1'b0, divisor};
                quotient[i] = 1'b1;
            end
        end
        remainder = part[7:0];
        div_zero = (divisor == 8'h00);
    end

endmodule

`default_nettype wire

//--- logic/aau_core.sv
/*
 * Arithmetic datapath of an 8-bit accumulator core: add, add with carry,
 * subtract with borrow, increment, decrement, data pointer increment,
 * multiply and divide, each held for its fixed number of cycles.
 * Assumes the decoder supplies working register values and indirect
 * pointers in the request, and that data memory reads answer in the
 * same cycle as the read strobe.
 */
// Notes on behaviour
// - Register, direct, indirect, immediate operands for add, add with carry and subtract with borrow
// - Add: 1/1 reg, 2/2 direct, 1/2 indirect, 2/2 immediate
// - Add with carry adds carry, same timing
// - Subtract with borrow, same timing as add
// - Step: acc 1, reg 2, memory 3; pointer 1
// - Multiply accumulator by auxiliary register, 2 cycles
// - Divide accumulator by auxiliary register, 6 cycles
`timescale 1ns/1ns
`default_nettype none

module aau_core (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire aau_pkg::aau_req_s req,
    output logic req_ready,
    output logic done,
    output logic [1:0] done_len,
    output logic [7:0] acc,
    output logic [7:0] aux_b,
    output logic carry,
    output logic overflow,
    output logic [15:0] data_pointer,
    output logic wb_valid,
    output logic [7:0] wb_data,
    output aau_pkg::aau_mem_s mem,
    input wire logic [7:0] mem_rdata
);

    // Sequencer states
    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } aau_state_e;

    aau_state_e state_reg; // Idle or holding a multi-cycle instruction
    logic [2:0] cnt_reg; // Cycles left, last one is CNT_LAST
    logic ready_reg; // Request port open
    aau_pkg::aau_req_s held_reg; // Instruction in flight
    logic [7:0] acc_reg; // Accumulator
    logic [7:0] aux_reg; // Auxiliary operand register
    logic carry_reg; // Carry flag
    logic ov_reg; // Overflow flag
    logic [15:0] dp_reg; // Data pointer
    logic done_reg; // Completion pulse
    logic [1:0] len_reg; // Length of completed instruction
    logic wb_valid_reg; // Working register write-back pulse
    logic [7:0] wb_data_reg; // Write-back value
    aau_pkg::aau_mem_s mem_reg; // Memory strobes

    logic accept; // Request taken this edge
    logic [2:0] req_cyc; // Execution time of the offered request
    logic fire; // Final edge of the current instruction
    aau_pkg::aau_req_s cur; // Instruction being worked on
    logic [7:0] opnd; // Selected operand
    logic [7:0] step_val; // Operand plus or minus one
    logic [8:0] sum9; // Add result with carry out
    logic [8:0] diff9; // Subtract result with borrow out
    logic [15:0] prod; // Multiply result
    logic [7:0] quot; // Divide quotient
    logic [7:0] rem; // Divide remainder
    logic div_zero; // Divisor is zero

    // Request handshake; single-cycle forms retire on the accepting edge
    assign accept = req_valid && ready_reg;
    assign req_cyc = aau_pkg::aau_cycles(req.op, req.mode);
    assign cur = (state_reg == ST_RUN) ? held_reg : req;
    assign fire = (accept && req_cyc == aau_pkg::CYC_LOAD) ||
                  (state_reg == ST_RUN && cnt_reg == aau_pkg::CNT_LAST);

    // Operand selection by addressing form
    always_comb begin
        if (aau_pkg::aau_uses_mem(cur.mode)) begin
            opnd = mem_rdata;
        end else if (cur.mode == aau_pkg::MD_ACC) begin
            opnd = acc_reg;
        end else begin
            opnd = cur.operand;
        end
    end

    // Arithmetic results; the carry term only joins for the carry forms
    always_comb begin
        step_val = (cur.op == aau_pkg::OP_INCREMENT) ? opnd + 8'h01 : opnd - 8'h01;
        sum9 = {1'b0, acc_reg} + {1'b0, opnd} +
               {8'h00, carry_reg && cur.op == aau_pkg::OP_ADD_WITH_CARRY};
        diff9 = {1'b0, acc_reg} - {1'b0, opnd} - {8'h00, carry_reg};
        // Widened first so the full 16-bit product is kept
        prod = {8'h00, acc_reg} * {8'h00, aux_reg};
    end

    // Divider settles long before the sixth cycle samples it
    aau_divider u_divider (
        .dividend(acc_reg),
        .divisor(aux_reg),
        .quotient(quot),
        .remainder(rem),
        .div_zero(div_zero)
    );

    // Sequencer: holds multi-cycle forms for their exact count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 3'h0;
            ready_reg <= 1'b1;
            held_reg <= '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // Longer forms close the port until their last edge
                    if (accept && req_cyc != aau_pkg::CYC_LOAD) begin
                        state_reg <= ST_RUN;
                        cnt_reg <= req_cyc - 3'h1;
                        ready_reg <= 1'b0;
                        held_reg <= req;
                    end
                end
                ST_RUN: begin
                    cnt_reg <= cnt_reg - 3'h1;
                    // Reopen on the final edge so the next one follows at once
                    if (cnt_reg == aau_pkg::CNT_LAST) begin
                        state_reg <= ST_IDLE;
                        ready_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    ready_reg <= 1'b1;
                end
            endcase
        end
    end

    // Accumulator, auxiliary register and flags, written on the final edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_reg <= aau_pkg::ACC_RST;
            aux_reg <= aau_pkg::AUX_RST;
            carry_reg <= aau_pkg::CARRY_RST;
            ov_reg <= 1'b0;
        end else if (fire) begin
            case (cur.op)
                aau_pkg::OP_ADD, aau_pkg::OP_ADD_WITH_CARRY: begin
                    acc_reg <= sum9[7:0];
                    carry_reg <= sum9[8];
                    ov_reg <= (acc_reg[7] == opnd[7]) && (sum9[7] != acc_reg[7]);
                end
                aau_pkg::OP_SUBTRACT_WITH_BORROW: begin
                    acc_reg <= diff9[7:0];
                    carry_reg <= diff9[8];
                    ov_reg <= (acc_reg[7] != opnd[7]) && (diff9[7] != acc_reg[7]);
                end
                aau_pkg::OP_INCREMENT, aau_pkg::OP_DECREMENT: begin
                    // Every step form lands here, only the accumulator form writes acc; flags untouched
                    if (cur.mode == aau_pkg::MD_ACC) begin
                        acc_reg <= step_val;
                    end
                end
                aau_pkg::OP_MULTIPLY: begin
                    // Low byte to accumulator, high byte to auxiliary
                    acc_reg <= prod[7:0];
                    aux_reg <= prod[15:8];
                    carry_reg <= 1'b0;
                    ov_reg <= |prod[15:8];
                end
                aau_pkg::OP_DIVIDE: begin
                    carry_reg <= 1'b0;
                    // Zero divisor leaves both registers as they were
                    if (div_zero) begin
                        ov_reg <= 1'b1;
                    end else begin
                        acc_reg <= quot;
                        aux_reg <= rem;
                        ov_reg <= 1'b0;
                    end
                end
                aau_pkg::OP_LOAD_ACC: begin
                    acc_reg <= opnd;
                end
                aau_pkg::OP_LOAD_AUX: begin
                    aux_reg <= opnd;
                end
                aau_pkg::OP_LOAD_CARRY: begin
                    carry_reg <= cur.operand[0];
                end
                default: begin
                    acc_reg <= acc_reg;
                end
            endcase
        end
    end

    // Data pointer, 16-bit wrap
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dp_reg <= aau_pkg::DP_RST;
        end else if (fire && cur.op == aau_pkg::OP_INC_DATA_POINTER) begin
            dp_reg <= dp_reg + 16'h0001;
        end
    end

    // Working register write-back, owned by the decoder's register bank
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_valid_reg <= 1'b0;
            wb_data_reg <= 8'h00;
        end else begin
            wb_valid_reg <= fire && cur.mode == aau_pkg::MD_WORKING_REG &&
                            (cur.op == aau_pkg::OP_INCREMENT ||
                             cur.op == aau_pkg::OP_DECREMENT);
            if (fire) begin
                wb_data_reg <= step_val;
            end
        end
    end

    // Data memory strobes: read in the first cycle, step write in the second
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_reg <= '0;
        end else begin
            mem_reg.rd <= accept && aau_pkg::aau_uses_mem(req.mode) &&
                          req.op != aau_pkg::OP_INC_DATA_POINTER &&
                          req.op != aau_pkg::OP_MULTIPLY &&
                          req.op != aau_pkg::OP_DIVIDE;
            if (accept) begin
                mem_reg.addr <= req.addr;
            end
            // Memory step: write back the adjusted byte, ends on last edge
            mem_reg.wr <= state_reg == ST_RUN && cnt_reg == aau_pkg::CNT_STEP_WRITE &&
                          aau_pkg::aau_uses_mem(cur.mode) &&
                          (cur.op == aau_pkg::OP_INCREMENT ||
                           cur.op == aau_pkg::OP_DECREMENT);
            if (state_reg == ST_RUN && cnt_reg == aau_pkg::CNT_STEP_WRITE) begin
                mem_reg.wdata <= step_val;
            end
        end
    end

    // Completion pulse with the instruction length for the fetch unit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            done_reg <= 1'b0;
            len_reg <= 2'h0;
        end else begin
            done_reg <= fire;
            if (fire) begin
                len_reg <= aau_pkg::aau_bytes(cur.op, cur.mode);
            end
        end
    end

    // Outputs straight from flip-flops
    assign req_ready = ready_reg;
    assign done = done_reg;
    assign done_len = len_reg;
    assign acc = acc_reg;
    assign aux_b = aux_reg;
    assign carry = carry_reg;
    assign overflow = ov_reg;
    assign data_pointer = dp_reg;
    assign wb_valid = wb_valid_reg;
    assign wb_data = wb_data_reg;
    assign mem = mem_reg;

endmodule

`default_nettype wire

//--- verification/aau_mem_model.sv
/*
 * Data memory on the far side of the arithmetic unit.
 * Assumes reads answer in the cycle of the read strobe, writes land at the edge.
 */
`timescale 1ns/1ns
`default_nettype none

module aau_mem_model (
    input wire logic clk_sys,
    input wire aau_pkg::aau_mem_s mem,
    output logic [7:0] mem_rdata
);
    logic [7:0] ram [0:255]; // Byte store, preset to address plus 10h
    logic [7:0] last_q; // Last byte read out

    // Preset contents the bench relies on
    initial begin
        for (int i = 0; i < 256; i++) begin
            ram[i] = 8'(i + 16);
        end
        last_q = 8'h00;
    end

    // Read answers only under the strobe; otherwise inverted junk, not stale data
    always @* begin
        mem_rdata = mem.rd ? ram[mem.addr] : ~last_q;
    end

    // Writes and read history
    always @(posedge clk_sys) begin
        if (mem.rd) begin
            last_q <= ram[mem.addr];
        end
        if (mem.wr) begin
            ram[mem.addr] <= mem.wdata;
        end
    end
endmodule

`default_nettype wire

//--- verification/aau_core_chk.sv
/*
 * Timing and result checks at the arithmetic unit's ports.
 * Assumes one clock domain and the request handshake of the core.
 */
`timescale 1ns/1ns
`default_nettype none

module aau_core_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire aau_pkg::aau_req_s req,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [1:0] done_len,
    input wire logic [7:0] acc,
    input wire logic [7:0] aux_b,
    input wire logic carry,
    input wire logic overflow,
    input wire logic [15:0] data_pointer,
    input wire logic wb_valid,
    input wire logic [7:0] wb_data,
    input wire aau_pkg::aau_mem_s mem,
    input wire logic [7:0] mem_rdata
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic tk; // Request taken
    logic ar; // Add family
    logic mm; // Memory operand
    logic st; // Step family
    logic wr; // Working register mode
    assign tk = req_valid && req_ready;
    assign ar = req.op inside {aau_pkg::OP_ADD, aau_pkg::OP_ADD_WITH_CARRY,
        aau_pkg::OP_SUBTRACT_WITH_BORROW};
    assign mm = req.mode inside {aau_pkg::MD_DIRECT, aau_pkg::MD_INDIRECT};
    assign st = req.op inside {aau_pkg::OP_INCREMENT, aau_pkg::OP_DECREMENT};
    assign wr = req.mode == aau_pkg::MD_WORKING_REG;

    a_add_reg_sum: assert property (tk && wr && req.op == aau_pkg::OP_ADD |=>
        done && req_ready && {carry, acc} == $past(acc) + $past(req.operand))
        else $error("add register result or timing wrong");
    a_add_with_carry_sum: assert property (tk && wr && req.op == aau_pkg::OP_ADD_WITH_CARRY |=>
        {carry, acc} == $past(acc) + $past(req.operand) + $past(carry))
        else $error("add with carry result wrong");
    a_subtract_with_borrow_diff: assert property (tk && wr && req.op == aau_pkg::OP_SUBTRACT_WITH_BORROW |=>
        {carry, acc} == {1'b0, $past(acc)} - $past(req.operand) - $past(carry))
        else $error("subtract with borrow result wrong");
    a_arith_slow: assert property (tk && ar && (mm || req.mode == aau_pkg::MD_IMMEDIATE)
        |=> !done && !req_ready ##1 done)
        else $error("two cycle arithmetic timing wrong");
    a_mem_fetch: assert property (tk && ar && mm |=> mem.rd && mem.addr == $past(req.addr))
        else $error("operand fetch wrong");
    a_step_mem: assert property (tk && st && mm |=> mem.rd ##1 mem.wr && !done ##1 done)
        else $error("memory step timing wrong");
    a_step_reg: assert property (tk && st && wr |=> !done ##1 done && wb_valid &&
        wb_data == $past(req.operand, 2) + ($past(req.op, 2) == aau_pkg::OP_INCREMENT ?
        8'h01 : 8'hFF))
        else $error("register step wrong");
    a_ptr_step: assert property (tk && req.op == aau_pkg::OP_INC_DATA_POINTER |=>
        done && data_pointer == $past(data_pointer) + 16'h0001)
        else $error("pointer step wrong");
    a_mul_prod: assert property (tk && req.op == aau_pkg::OP_MULTIPLY |=> !done ##1
        done && {aux_b, acc} == $past(acc, 2) * $past(aux_b, 2))
        else $error("multiply wrong");
    a_div_time: assert property (tk && req.op == aau_pkg::OP_DIVIDE |=> !done [*5] ##1
        done && ($past(aux_b, 6) == 8'h00 ? overflow && acc == $past(acc, 6) :
        !overflow && acc == $past(acc, 6) / $past(aux_b, 6) &&
        aux_b == $past(acc, 6) % $past(aux_b, 6)))
        else $error("divide wrong");

    c_divide: cover property (tk && req.op == aau_pkg::OP_DIVIDE);
    c_step_mem: cover property (tk && st && mm);
    c_carry_out: cover property (done && carry);
endmodule

bind aau_core aau_core_chk u_chk (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .done_len(done_len), .acc(acc),
    .aux_b(aux_b), .carry(carry), .overflow(overflow), .data_pointer(data_pointer),
    .wb_valid(wb_valid), .wb_data(wb_data), .mem(mem), .mem_rdata(mem_rdata));

`default_nettype wire

//--- verification/test_accumulator_arithmetic_unit.sv
/*
 * Self-checking bench of the arithmetic unit with its data memory model.
 * Assumes memory byte at address a holds a plus 10h at start.
 */
`timescale 1ns/1ns
`default_nettype none

module test_accumulator_arithmetic_unit;
    logic clk_sys, rst, req_valid, req_ready, done, carry, overflow, wb_valid;
    aau_pkg::aau_req_s req; // Request carrier
    aau_pkg::aau_mem_s mem; // Memory strobes
    logic [1:0] done_len;
    logic [7:0] acc, aux_b, wb_data, mem_rdata;
    logic [15:0] data_pointer;
    int err_count, cmp_count, k;

    // One row: op, mode, operand, address, then acc, carry, aux, length, cycles
    typedef struct packed {
        logic [3:0] op;
        logic [2:0] md;
        logic [7:0] opd, adr, acc;
        logic cy;
        logic [7:0] aux;
        logic [1:0] len;
        logic [2:0] cyc;
    } aau_row_s;
    // Chained: each row starts from the state left by the one before
    aau_row_s rows [22] = '{
        '{4'h8,3'h4,8'hF0,8'h00,8'hF0,1'h0,8'h00,2'h2,3'h1},
        '{4'h0,3'h1,8'h20,8'h00,8'h10,1'h1,8'h00,2'h1,3'h1},
        '{4'h1,3'h2,8'h00,8'h05,8'h26,1'h0,8'h00,2'h2,3'h2},
        '{4'h1,3'h4,8'hE0,8'h00,8'h06,1'h1,8'h00,2'h2,3'h2},
        '{4'h2,3'h3,8'h00,8'h03,8'hF2,1'h1,8'h00,2'h1,3'h2},
        '{4'h2,3'h1,8'h01,8'h00,8'hF0,1'h0,8'h00,2'h1,3'h1},
        '{4'h0,3'h3,8'h00,8'h20,8'h20,1'h1,8'h00,2'h1,3'h2},
        '{4'h2,3'h4,8'h10,8'h00,8'h0F,1'h0,8'h00,2'h2,3'h2},
        '{4'h3,3'h0,8'h00,8'h00,8'h10,1'h0,8'h00,2'h1,3'h1},
        '{4'h4,3'h0,8'h00,8'h00,8'h0F,1'h0,8'h00,2'h1,3'h1},
        '{4'h3,3'h1,8'hFF,8'h00,8'h0F,1'h0,8'h00,2'h1,3'h2},
        '{4'h4,3'h2,8'h00,8'h40,8'h0F,1'h0,8'h00,2'h2,3'h3},
        '{4'h3,3'h3,8'h00,8'h40,8'h0F,1'h0,8'h00,2'h1,3'h3},
        '{4'h0,3'h2,8'h00,8'h40,8'h5F,1'h0,8'h00,2'h2,3'h2},
        '{4'h9,3'h4,8'h07,8'h00,8'h5F,1'h0,8'h07,2'h2,3'h1},
        '{4'h7,3'h0,8'h00,8'h00,8'h0D,1'h0,8'h04,2'h1,3'h6},
        '{4'h9,3'h4,8'h14,8'h00,8'h0D,1'h0,8'h14,2'h2,3'h1},
        '{4'h6,3'h0,8'h00,8'h00,8'h04,1'h0,8'h01,2'h1,3'h2},
        '{4'h5,3'h0,8'h00,8'h00,8'h04,1'h0,8'h01,2'h1,3'h1},
        '{4'h4,3'h1,8'h00,8'h00,8'h04,1'h0,8'h01,2'h1,3'h2},
        '{4'hA,3'h4,8'h01,8'h00,8'h04,1'h1,8'h01,2'h1,3'h1},
        '{4'h1,3'h1,8'h00,8'h00,8'h05,1'h0,8'h01,2'h1,3'h1}};

    aau_core dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .done(done), .done_len(done_len), .acc(acc), .aux_b(aux_b),
        .carry(carry), .overflow(overflow), .data_pointer(data_pointer),
        .wb_valid(wb_valid), .wb_data(wb_data), .mem(mem), .mem_rdata(mem_rdata));
    aau_mem_model u_mem (.clk_sys(clk_sys), .mem(mem), .mem_rdata(mem_rdata));

    // 50 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // Single compare for every result kind
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("errors %0d checks %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One request at a falling edge; counts cycles until done, bounded
    task automatic issue(input logic [3:0] op, input logic [2:0] md, input logic [7:0] opd,
        input logic [7:0] adr, output int n);
        @(negedge clk_sys);
        req_valid = 1'b1;
        req.op = aau_pkg::aau_op_e'(op);
        req.mode = aau_pkg::aau_mode_e'(md);
        req.operand = opd;
        req.addr = adr;
        chk("ready", 16'h0001, 16'(req_ready));
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 20) begin
            err_count++;
            summarize();
        end
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        err_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        chk("rst_regs", 16'h0000, {acc, aux_b});
        chk("rst_dp", 16'h0000, data_pointer);
        chk("rst_flags", 16'h0001, {carry, overflow, req_ready});
        // Ordinary cases from the table
        foreach (rows[i]) begin
            issue(rows[i].op, rows[i].md, rows[i].opd, rows[i].adr, k);
            chk("cycles", 16'(rows[i].cyc), 16'(k));
            chk("length", 16'(rows[i].len), 16'(done_len));
            chk("acc", 16'(rows[i].acc), 16'(acc));
            chk("carry", 16'(rows[i].cy), 16'(carry));
            chk("aux", 16'(rows[i].aux), 16'(aux_b));
        end
        chk("pointer", 16'h0001, data_pointer);
        // Divide by zero leaves the accumulator alone
        issue(4'h9, 3'h4, 8'h00, 8'h00, k);
        issue(4'h7, 3'h0, 8'h00, 8'h00, k);
        chk("div0", 16'h0516, {acc, 3'h0, overflow, 1'h0, 3'(k)});
        // Back to back register adds, request held over two edges
        @(negedge clk_sys);
        req_valid = 1'b1;
        req.op = aau_pkg::OP_ADD;
        req.mode = aau_pkg::MD_WORKING_REG;
        req.operand = 8'h01;
        repeat (2) @(negedge clk_sys);
        req_valid = 1'b0;
        chk("b2b", 16'h0701, {acc, 7'h00, done});
        // Reset while idle after the adds clears state
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("rerst", 16'h0000, {acc, 6'h00, carry, overflow});
        chk("rerst_dp", 16'h0000, data_pointer);
        rst = 1'b0;
        // First request after release is taken at once
        issue(4'h0, 3'h1, 8'h3C, 8'h00, k);
        chk("post_rst", 16'h3C01, {acc, 5'h00, 3'(k)});
        summarize();
    end
endmodule

`default_nettype wire
